// [design/sls_link_tx.sv]
/*
 sls_link_tx: converter-side link timing; divides the system clock into the
 conversion rate, delays samples to the lane and fast-detect outputs, runs the
 comma phase against the sync request and reference, and times wake-up.
 Assumes all inputs synchronous to CLK_SYS_I; the serializer sits downstream
 and drains one word per sample.
*/
`timescale 1ns/1ps
module sls_link_tx import sls_pkg::*; #(
   parameter int FRAMES_PER_MF = 32,
   parameter int WAKE_PD_CYCLES = WAKE_PD_CYC,
   parameter int WAKE_SB_CYCLES = WAKE_SB_CYC,
   parameter int WAKE_OUT_CYCLES = WAKE_OUT_CYC
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [3:0] DIV_RATIO_I,
   input wire logic SUBCLASS1_I,
   input wire logic SYSREF_I,
   input wire logic LINK_SYNC_REQUEST_N_I,
   input wire logic [SAMPLE_W-1:0] SAMPLE_I,
   input wire logic [SAMPLE_W-1:0] FD_THRESH_I,
   input wire logic [1:0] PWR_MODE_I,
   input wire logic OUT_PDWN_I,
   input wire logic LANE_READY_I,
   output logic [SAMPLE_W:0] LANE_WORD_O,
   output logic LANE_VALID_O,
   output logic FAST_DETECT_O,
   output logic CONV_STROBE_O,
   output logic CONV_READY_O,
   output logic LANE_ENABLE_O,
   output logic CGS_ACTIVE_O,
   output logic [4:0] UI_PER_SAMPLE_O
);
   localparam int MF_CYC = FRAMES_PER_MF;
   localparam int MF_W = $clog2(SC1_MF * MF_CYC + 1);
   localparam int WK_W = $clog2(WAKE_PD_CYCLES + 1);

   function automatic logic [3:0] legal_div(input logic [3:0] r);
      legal_div = (r == 4'h0 || r > 4'(DIV_MAX)) ? DIV_RESET : r;
   endfunction

   logic [3:0] div_cnt_reg;
   logic conv_en;
   logic [SAMPLE_W-1:0] lane_pipe_reg [LANE_LAT];
   logic [FD_LAT-1:0] fd_pipe_reg;
   sls_link_type link_reg;
   logic [MF_W-1:0] mf_cnt_reg;
   logic sysref_d_reg;
   logic [WK_W-1:0] wake_cnt_reg;
   logic [WK_W-1:0] owake_cnt_reg;
   logic [1:0] pwr_d_reg;
   logic opd_d_reg;
   logic conv_up;
   logic lane_up;
   sls_word_type src_word;
   logic src_valid;
   logic src_ready;
   logic [SAMPLE_W:0] buf_data;
   logic buf_valid;

   // conversion enable from integer divider
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || div_cnt_reg >= legal_div(DIV_RATIO_I) - 4'h1) begin
         div_cnt_reg <= 4'h0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
      end
   end
   assign conv_en = (div_cnt_reg == 4'h0) && conv_up;

   // sample to lane delay line
   always_ff @(posedge CLK_SYS_I) begin
      if (conv_en) begin
         lane_pipe_reg[0] <= SAMPLE_I;
         for (int i = 1; i < LANE_LAT; i++) begin
            lane_pipe_reg[i] <= lane_pipe_reg[i-1];
         end
      end
   end

   // fast detect delay line
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         fd_pipe_reg <= '0;
      end else if (conv_en) begin
         fd_pipe_reg <= {fd_pipe_reg[FD_LAT-2:0], (SAMPLE_I >= FD_THRESH_I)};
      end
   end

   // wake-up timers for converter and output
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         pwr_d_reg <= SLS_PWR_ON;
         opd_d_reg <= 1'b0;
         wake_cnt_reg <= '0;
         owake_cnt_reg <= '0;
      end else begin
         pwr_d_reg <= PWR_MODE_I;
         opd_d_reg <= OUT_PDWN_I;
         if (PWR_MODE_I != SLS_PWR_ON) begin
            wake_cnt_reg <= '0;
         end else if (pwr_d_reg == SLS_PWR_DOWN) begin
            wake_cnt_reg <= WK_W'(WAKE_PD_CYCLES);
         end else if (pwr_d_reg == SLS_PWR_STANDBY) begin
            wake_cnt_reg <= WK_W'(WAKE_SB_CYCLES);
         end else if (wake_cnt_reg != '0) begin
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
         end
         if (OUT_PDWN_I) begin
            owake_cnt_reg <= '0;
         end else if (opd_d_reg) begin
            owake_cnt_reg <= WK_W'(WAKE_OUT_CYCLES);
         end else if (owake_cnt_reg != '0) begin
            owake_cnt_reg <= owake_cnt_reg - 1'b1;
         end
      end
   end
   assign conv_up = (PWR_MODE_I == SLS_PWR_ON) && (wake_cnt_reg == '0);
   assign lane_up = !OUT_PDWN_I && (owake_cnt_reg == '0) && conv_up;

   // link start: wait, comma phase, then data
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || !lane_up) begin
         link_reg <= SLS_IDLE;
         mf_cnt_reg <= '0;
         sysref_d_reg <= 1'b0;
      end else begin
         sysref_d_reg <= SYSREF_I;
         unique case (link_reg)
            SLS_IDLE: begin
               if (!SUBCLASS1_I && !LINK_SYNC_REQUEST_N_I) begin
                  link_reg <= SLS_WAIT;
                  mf_cnt_reg <= MF_W'(SC0_MF * MF_CYC);
               end else if (SUBCLASS1_I && SYSREF_I && !sysref_d_reg) begin
                  link_reg <= SLS_WAIT;
                  mf_cnt_reg <= MF_W'(SC1_MF * MF_CYC);
               end
            end
            SLS_WAIT: begin
               if (conv_en) mf_cnt_reg <= mf_cnt_reg - 1'b1;
               if (mf_cnt_reg == '0) begin
                  link_reg <= SLS_CGS;
                  mf_cnt_reg <= MF_W'(CGS_MF * MF_CYC);
               end
            end
            SLS_CGS: begin
               if (conv_en && mf_cnt_reg != '0) mf_cnt_reg <= mf_cnt_reg - 1'b1;
               if (mf_cnt_reg == '0 && LINK_SYNC_REQUEST_N_I) begin
                  link_reg <= SLS_DATA;
               end
            end
            SLS_DATA: begin
               if (!LINK_SYNC_REQUEST_N_I) begin
                  link_reg <= SLS_CGS;
                  mf_cnt_reg <= MF_W'(CGS_MF * MF_CYC);
               end
            end
         endcase
      end
   end

   // source word into buffer, one per conversion in the comma and data phases
   assign src_word.is_comma = (link_reg != SLS_DATA);
   assign src_word.sample = (link_reg == SLS_DATA) ? lane_pipe_reg[LANE_LAT-1]
                                                   : {{(SAMPLE_W-8){1'b0}}, K28_5};
   assign src_valid = conv_en && (link_reg == SLS_CGS || link_reg == SLS_DATA);

   sls_skid_buf #(.WIDTH(SAMPLE_W + 1)) u_buf (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .in_data_i(src_word),
      .in_valid_i(src_valid),
      .in_ready_o(src_ready),
      .out_data_o(buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(LANE_READY_I && !LANE_VALID_O)
   );

   // registered outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         LANE_WORD_O <= '0;
         LANE_VALID_O <= 1'b0;
         FAST_DETECT_O <= 1'b0;
         CONV_STROBE_O <= 1'b0;
         CONV_READY_O <= 1'b0;
         LANE_ENABLE_O <= 1'b0;
         CGS_ACTIVE_O <= 1'b0;
         UI_PER_SAMPLE_O <= 5'(UI_PER_SAMPLE);
      end else begin
         // words left in the buffer when the lane drops are flushed, not sent
         LANE_VALID_O <= buf_valid && LANE_READY_I && !LANE_VALID_O && lane_up;
         if (buf_valid && LANE_READY_I && !LANE_VALID_O) LANE_WORD_O <= buf_data;
         FAST_DETECT_O <= fd_pipe_reg[FD_LAT-1];
         CONV_STROBE_O <= conv_en;
         CONV_READY_O <= conv_up && src_ready;
         LANE_ENABLE_O <= lane_up;
         CGS_ACTIVE_O <= (link_reg == SLS_CGS);
         UI_PER_SAMPLE_O <= 5'(UI_PER_SAMPLE);
      end
   end
endmodule

// [design/sls_pkg.sv]
/*
 sls_pkg: constants, states and carriers for the serial link startup timing block.
 Assumes one 200 MHz system clock; the conversion clock is a divided enable pulse.
*/
// Notes on behaviour
// - subclass 0: comma after sync low, 5 multiframes
// - subclass 1: comma 6 multiframes after reference edge
// - comma phase lasts at least one multiframe
// - each sample takes 20 lane bit times
// - latency 36 to lane, 7 to fast detect
// - conversion rate is divided input clock
// - divider supports ratios one through eight
// - wake from power-down 250 us, standby 10 us
// - wake from output power-down 50 us
package sls_pkg;
   localparam int CLK_MHZ = 200;
   localparam int SAMPLE_W = 14;
   localparam int UI_PER_SAMPLE = 20;
   localparam int LANE_LAT = 36;
   localparam int FD_LAT = 7;
   localparam int SC0_MF = 5;
   localparam int SC1_MF = 6;
   localparam int CGS_MF = 1;
   localparam int DIV_MAX = 8;
   localparam int WAKE_PD_US = 250;
   localparam int WAKE_SB_US = 10;
   localparam int WAKE_OUT_US = 50;
   localparam int WAKE_PD_CYC = WAKE_PD_US * CLK_MHZ;
   localparam int WAKE_SB_CYC = WAKE_SB_US * CLK_MHZ;
   localparam int WAKE_OUT_CYC = WAKE_OUT_US * CLK_MHZ;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [3:0] DIV_RESET = 4'h1;
   localparam logic [SAMPLE_W-1:0] FD_THRESH_RESET = 14'h3000;

   typedef enum logic [1:0] {SLS_PWR_ON, SLS_PWR_STANDBY, SLS_PWR_DOWN} sls_pwr_type;
   typedef enum {SLS_IDLE, SLS_WAIT, SLS_CGS, SLS_DATA} sls_link_type;

   typedef struct packed {
      logic is_comma;
      logic [SAMPLE_W-1:0] sample;
   } sls_word_type;
endpackage

// [design/sls_skid_buf.sv]
/*
 sls_skid_buf: two-entry buffer with valid and ready on both sides.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module sls_skid_buf import sls_pkg::*; #(
   parameter int WIDTH = SAMPLE_W + 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [WIDTH-1:0] mem_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   // handshakes
   assign push = in_valid_i && (count_reg != 2'h2);
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count_reg != 2'h2);
   assign out_valid_o = (count_reg != 2'h0);
   assign out_data_o = mem_reg[rd_ptr_reg];

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// [tb/sls_rx_model.sv]
/*
 sls_rx_model: receiver logic on the far side of the lane.
 Assumes the same clock and reset as the transmitter.
*/
`timescale 1ns/1ps
module sls_rx_model import sls_pkg::*; #(
   parameter int MF = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [SAMPLE_W:0] word_i,
   input wire logic valid_i,
   output logic sync_n_o,
   output logic ready_o
);
   int commas = 0;
   int idle = 0;
   int tick = 0;
   // one-cycle serializer stall in every five
   always_ff @(posedge clk_i) begin
      tick <= tick + 1;
      ready_o <= (tick % 5) != 3;
   end
   // request sync after reset or a silent lane, release after a multiframe of commas
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         commas <= 0;
         idle <= 0;
         sync_n_o <= 1'b1;
      end else begin
         if (valid_i)
            idle <= 0;
         else if (idle < 32)
            idle <= idle + 1;
         if (idle == 31)
            commas <= 0;
         else if (valid_i && word_i == {1'b1, 6'h00, K28_5})
            commas <= commas + 1;
         sync_n_o <= (commas >= MF);
      end
   end
endmodule

// [tb/sls_chk.sv]
/*
 sls_chk: port assertions for the link timing block.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sls_chk import sls_pkg::*; #(
   parameter int FRAMES_PER_MF = 32
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [3:0] DIV_RATIO_I,
   input wire logic SUBCLASS1_I,
   input wire logic LINK_SYNC_REQUEST_N_I,
   input wire logic [1:0] PWR_MODE_I,
   input wire logic OUT_PDWN_I,
   input wire logic [SAMPLE_W:0] LANE_WORD_O,
   input wire logic LANE_VALID_O,
   input wire logic CONV_STROBE_O,
   input wire logic CONV_READY_O,
   input wire logic LANE_ENABLE_O,
   input wire logic CGS_ACTIVE_O,
   input wire logic [4:0] UI_PER_SAMPLE_O
);
   localparam int WAKE_BOUND = 60;
   int wait_cnt;
   int cgs_cnt;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   // conversions since sync request, and within the comma phase
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || LINK_SYNC_REQUEST_N_I || CGS_ACTIVE_O)
         wait_cnt <= 0;
      else if (CONV_STROBE_O)
         wait_cnt <= wait_cnt + 1;
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || !CGS_ACTIVE_O)
         cgs_cnt <= 0;
      else if (CONV_STROBE_O)
         cgs_cnt <= cgs_cnt + 1;
   end
   a_ui_twenty: assert property (UI_PER_SAMPLE_O == 5'h14) else $error("ui count wrong");
   a_valid_pulse: assert property (LANE_VALID_O |=> !LANE_VALID_O) else $error("valid held");
   a_lane_off: assert property (!LANE_ENABLE_O |-> !LANE_VALID_O) else $error("word while off");
   a_comma_word: assert property (LANE_VALID_O && CGS_ACTIVE_O |->
      LANE_WORD_O == {1'b1, 6'h00, K28_5}) else $error("bad comma");
   a_strobe_gap: assert property (CONV_STROBE_O && DIV_RATIO_I == 4'h2 |=>
      !CONV_STROBE_O) else $error("strobe too close");
   a_sc0_wait: assert property ($rose(CGS_ACTIVE_O) && !SUBCLASS1_I |->
      wait_cnt >= SC0_MF * FRAMES_PER_MF - 1) else $error("comma too early");
   a_cgs_length: assert property ($fell(CGS_ACTIVE_O) |->
      cgs_cnt >= CGS_MF * FRAMES_PER_MF - 1) else $error("comma phase short");
   a_pd_ready: assert property (PWR_MODE_I == 2'h2 |=> !CONV_READY_O) else $error("ready in pd");
   a_wake_out: assert property ($fell(OUT_PDWN_I) && PWR_MODE_I == 2'h0 |->
      ##[1:WAKE_BOUND] LANE_ENABLE_O) else $error("lane wake slow");
   c_cgs: cover property ($rose(CGS_ACTIVE_O));
   c_data: cover property (LANE_VALID_O && !LANE_WORD_O[SAMPLE_W]);
   c_wake: cover property ($rose(LANE_ENABLE_O));
endmodule
bind sls_link_tx sls_chk #(.FRAMES_PER_MF(FRAMES_PER_MF)) i_chk (.CLK_SYS_I(CLK_SYS_I),
   .RST_N_I(RST_N_I), .DIV_RATIO_I(DIV_RATIO_I), .SUBCLASS1_I(SUBCLASS1_I),
   .LINK_SYNC_REQUEST_N_I(LINK_SYNC_REQUEST_N_I), .PWR_MODE_I(PWR_MODE_I),
   .OUT_PDWN_I(OUT_PDWN_I), .LANE_WORD_O(LANE_WORD_O), .LANE_VALID_O(LANE_VALID_O),
   .CONV_STROBE_O(CONV_STROBE_O), .CONV_READY_O(CONV_READY_O),
   .LANE_ENABLE_O(LANE_ENABLE_O), .CGS_ACTIVE_O(CGS_ACTIVE_O),
   .UI_PER_SAMPLE_O(UI_PER_SAMPLE_O));

// [tb/tb_top.sv]
/*
 tb_top: drives the link block against the receiver model, scoreboards lane data.
 Assumes a 200 MHz clock and shortened multiframe and wake counts.
*/
`timescale 1ns/1ps
module tb_top import sls_pkg::*; ;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sc1 = 1'b0;
   logic sysref = 1'b0;
   logic [SAMPLE_W-1:0] smp = '0;
   logic [1:0] pwr = 2'h0;
   logic opd = 1'b0;
   logic [3:0] div = 4'h3;
   logic [SAMPLE_W-1:0] thr = 14'h2000;
   logic sync_n, rdy, valid, fd, strobe, cready, lane_en, cgs, chk_on, synced;
   logic [SAMPLE_W:0] word;
   logic [4:0] ui;
   logic [SAMPLE_W-1:0] exp_q[$];
   int miscompares = 0;
   int comparisons = 0;
   int seed = 180;
   int cycles = 0;
   int i;
   sls_link_tx #(.FRAMES_PER_MF(4), .WAKE_PD_CYCLES(20), .WAKE_SB_CYCLES(5),
      .WAKE_OUT_CYCLES(10)) i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .DIV_RATIO_I(div), .SUBCLASS1_I(sc1), .SYSREF_I(sysref),
      .LINK_SYNC_REQUEST_N_I(sync_n), .SAMPLE_I(smp), .FD_THRESH_I(thr),
      .PWR_MODE_I(pwr), .OUT_PDWN_I(opd), .LANE_READY_I(rdy), .LANE_WORD_O(word),
      .LANE_VALID_O(valid), .FAST_DETECT_O(fd), .CONV_STROBE_O(strobe),
      .CONV_READY_O(cready), .LANE_ENABLE_O(lane_en), .CGS_ACTIVE_O(cgs),
      .UI_PER_SAMPLE_O(ui));
   sls_rx_model #(.MF(4)) i_rx (.clk_i(clk), .rst_n_i(rst_n), .word_i(word),
      .valid_i(valid), .sync_n_o(sync_n), .ready_o(rdy));
   // clock and cycle ceiling
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic cmp_val(string name, logic [SAMPLE_W:0] expv, logic [SAMPLE_W:0] got);
      comparisons++;
      if (got !== expv) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, expv, got);
      end
   endtask
   task finish_test;
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // note each taken sample, then offer a fresh random one
   always @(posedge clk) begin
      if (strobe) begin
         exp_q.push_back(smp);
         smp <= SAMPLE_W'($random(seed));
      end
   end
   // lane data against the sample noted one pipeline depth earlier
   always @(posedge clk) begin
      if (chk_on && valid && !word[SAMPLE_W] && exp_q.size() > LANE_LAT) begin
         if (!synced)
            while (exp_q.size() > LANE_LAT + 1) exp_q.pop_front();
         synced = 1'b1;
         cmp_val("lane sample", {1'b0, exp_q.pop_front()}, word);
      end
   end
   initial begin
      chk_on = 1'b1;
      synced = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 3000 && cgs !== 1'b1; i++) @(posedge clk);
      cmp_val("comma phase", 15'h1, {14'h0, cgs});
      repeat (400) @(posedge clk);
      cmp_val("data phase", 15'h0, {14'h0, cgs});
      chk_on = 1'b0;
      opd <= 1'b1;
      repeat (20) @(posedge clk);
      cmp_val("lane enable", 15'h0, {14'h0, lane_en});
      opd <= 1'b0;
      for (i = 0; i < 200 && lane_en !== 1'b1; i++) @(posedge clk);
      cmp_val("lane enable", 15'h1, {14'h0, lane_en});
      pwr <= 2'h2;
      repeat (20) @(posedge clk);
      cmp_val("conv ready", 15'h0, {14'h0, cready});
      pwr <= 2'h0;
      for (i = 0; i < 200 && cready !== 1'b1; i++) @(posedge clk);
      cmp_val("conv ready", 15'h1, {14'h0, cready});
      synced = 1'b0;
      chk_on = 1'b1;
      repeat (300) @(posedge clk);
      chk_on = 1'b0;
      rst_n <= 1'b0;
      sc1 <= 1'b1;
      div <= 4'h2;
      thr <= SAMPLE_W'($random(seed));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      sysref <= 1'b1;
      for (i = 0; i < 3000 && cgs !== 1'b1; i++) @(posedge clk);
      cmp_val("sc1 delay", 15'h1, {14'h0, i >= SC1_MF * 4 * 2 - 2});
      sysref <= 1'b0;
      repeat (100) @(posedge clk);
      finish_test();
   end
endmodule
